//--- hw/ccwm_regs.svh
// Purpose: offsets, field positions, reset values and timing counts of the control bank
// Assumes: 200 MHz mclk, 8-bit register port
// Notes:   counts derived from times and the clock period
`ifndef CCWM_REGS_SVH
`define CCWM_REGS_SVH
`define CCWM_OFF_WDOG      8'h0D
`define CCWM_OFF_ILIM      8'h0E
`define CCWM_OFF_PROGRAMMED_CHARGE_CURRENT      8'h0F
`define CCWM_OFF_TEMP      8'h10
`define CCWM_RST_WDOG      8'h52
`define CCWM_RST_ILIM      8'h05
`define CCWM_RST_PROGRAMMED_CHARGE_CURRENT      8'h00
`define CCWM_RST_TEMP      8'h10
`define CCWM_MASK_PROGRAMMED_CHARGE_CURRENT_WR  8'h80
`define CCWM_MASK_TEMP_WR  8'h1F
`define CCWM_B_WDOG_EN     7
`define CCWM_B_WDOG_RST    6
`define CCWM_F_WDOG_TO     5:4
`define CCWM_B_HALVE       3
`define CCWM_B_OCP         2
`define CCWM_B_GUV         1
`define CCWM_B_RETRIG      0
`define CCWM_B_GO          7
`define CCWM_F_DEG         6:5
`define CCWM_F_INTVL       4:3
`define CCWM_F_VTH         2:0
`define CCWM_F_RESULT      6:3
`define CCWM_B_TEMP_EN     4
`define CCWM_B_COOL_I      3
`define CCWM_B_WARM_I      2
`define CCWM_B_COOL_V      1
`define CCWM_B_WARM_V      0
`define CCWM_CLK_HZ        200000000
`define CCWM_MS_TO_CYC(ms) ((ms) * (`CCWM_CLK_HZ / 1000))
`define CCWM_WDOG_S_0      8
`define CCWM_WDOG_S_1      40
`define CCWM_WDOG_S_2      80
`define CCWM_WDOG_S_3      160
`define CCWM_RESTORE_MS_0  200
`define CCWM_RESTORE_MS_1  500
`define CCWM_RETRIG_MS     2
`define CCWM_CNT_W         36
`endif

//--- hw/ccwm_pkg.sv
// Purpose: types of the control bank
// Assumes: nothing
// Notes:   counters are wide enough for 160 s at 200 MHz
package ccwm_pkg;
   typedef enum logic [1:0] {WD_IDLE, WD_RUN, WD_RESTORE} ccwm_wd_t;
   typedef struct packed {
      logic [7:0] wdog;
      logic [7:0] ilim;
      logic [7:0] programmed_charge_current;
      logic [7:0] temp;
   } ccwm_bank_t;
   typedef struct packed {
      ccwm_bank_t  bank;
      ccwm_wd_t    wd_state;
      logic [35:0] wd_cnt;
      logic        wd_pending;
      logic        irq_released;
      logic [35:0] rt_cnt;
      logic [7:0]  rdata;
      logic        ilim_start;
      logic        programmed_charge_current_start;
      logic        restore;
   } ccwm_state_t;
   typedef struct packed {
      logic       halve_current;
      logic       ocp_high;
      logic       gate_uv_allow;
      logic [2:0] ilim_threshold;
      logic [1:0] ilim_deglitch;
      logic [1:0] ilim_interval;
      logic       temp_enable;
      logic       cool_current_full;
      logic       warm_current_full;
      logic       cool_voltage_full;
      logic       warm_voltage_full;
   } ccwm_ctrl_t;
endpackage

//--- hw/ccwm_bank.sv
// Purpose: watchdog, measurement and temperature-region control registers
// Assumes: serial bus decoder outside presents one-cycle read and write strobes
// Notes:   analog loops and comparators sit outside; this block only drives their controls
// Summary of operation
// - watchdog runs only while enable bit 7 of 0x0D is set; reset off.
// - timeout field selects 8, 40, 80 or 160 s to watchdog request.
// - after expiry wait 200 or 500 ms, then restore bus configuration.
// - retrigger write releases interrupt, re-asserts after 2 ms if pending, self-clears.
// - bit 3 of 0x0D halves programmed charge current.
// - bit 2 selects inductor overcurrent level, low or high.
// - bit 1 low forces gate undervoltage function off.
// - writing 1 to bit 7 of 0x0E starts input-limit measurement with threshold.
// - deglitch and detection interval fields steer input-limit measurement.
// - writing 1 to bit 7 of 0x0F starts charge-current measurement; writing 0 clears the go bit.
// - charge-current result reported read-only in bits 6:3, reset zero.
// - temperature-region adjustments apply only while bit 4 of 0x10 set.
// - cool region current half unless bit 3 set.
// - warm region current half unless bit 2 set.
// - cool region voltage lowered 0.2 V unless bit 1 set.
// - warm region voltage lowered 0.2 V unless bit 0 set.
`timescale 1ns/10ps
`include "ccwm_regs.svh"
module ccwm_bank
   import ccwm_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       ilim_done,
   input  wire logic       programmed_charge_current_done,
   input  wire logic [3:0] programmed_charge_current_result,
   input  wire logic       other_event,
   output logic            ilim_measure_start,
   output logic            programmed_charge_current_measure_start,
   output logic            config_restore,
   output logic            irq_active,
   output ccwm_ctrl_t      ctrl
);
   localparam logic [35:0] WD_CYC0 = 36'(`CCWM_WDOG_S_0 * 64'(`CCWM_CLK_HZ));
   localparam logic [35:0] WD_CYC1 = 36'(`CCWM_WDOG_S_1 * 64'(`CCWM_CLK_HZ));
   localparam logic [35:0] WD_CYC2 = 36'(`CCWM_WDOG_S_2 * 64'(`CCWM_CLK_HZ));
   localparam logic [35:0] WD_CYC3 = 36'(`CCWM_WDOG_S_3 * 64'(`CCWM_CLK_HZ));
   localparam logic [35:0] RS_CYC0 = 36'(`CCWM_MS_TO_CYC(`CCWM_RESTORE_MS_0));
   localparam logic [35:0] RS_CYC1 = 36'(`CCWM_MS_TO_CYC(`CCWM_RESTORE_MS_1));
   localparam logic [35:0] RT_CYC  = 36'(`CCWM_MS_TO_CYC(`CCWM_RETRIG_MS));

   ccwm_state_t s_reg;
   ccwm_state_t s_next;

   function automatic logic [35:0] wd_limit(input logic [1:0] sel);
      unique case (sel)
         2'h0: wd_limit = WD_CYC0;
         2'h1: wd_limit = WD_CYC1;
         2'h2: wd_limit = WD_CYC2;
         2'h3: wd_limit = WD_CYC3;
      endcase
   endfunction

   logic wr_hit_wdog;
   logic wr_hit_ilim;
   logic wr_hit_programmed_charge_current;
   logic wr_hit_temp;
   assign wr_hit_wdog = reg_wr && (reg_addr == `CCWM_OFF_WDOG);
   assign wr_hit_ilim = reg_wr && (reg_addr == `CCWM_OFF_ILIM);
   assign wr_hit_programmed_charge_current = reg_wr && (reg_addr == `CCWM_OFF_PROGRAMMED_CHARGE_CURRENT);
   assign wr_hit_temp = reg_wr && (reg_addr == `CCWM_OFF_TEMP);

   always_comb begin
      s_next = s_reg;
      s_next.ilim_start = 1'b0;
      s_next.programmed_charge_current_start = 1'b0;
      s_next.restore    = 1'b0;
      // host writes; any register read or write, at any address, counts as the watchdog being serviced
      if (wr_hit_wdog) begin
         s_next.bank.wdog = reg_wdata;
      end
      if (wr_hit_ilim) begin
         s_next.bank.ilim = reg_wdata;
         if (reg_wdata[`CCWM_B_GO]) begin
            s_next.ilim_start = 1'b1;
         end
      end
      if (wr_hit_programmed_charge_current) begin
         // result bits are read-only, low bits reserved
         s_next.bank.programmed_charge_current[`CCWM_B_GO] = reg_wdata[`CCWM_B_GO];
         if (reg_wdata[`CCWM_B_GO]) begin
            s_next.programmed_charge_current_start = 1'b1;
         end
      end
      if (wr_hit_temp) begin
         s_next.bank.temp = reg_wdata & `CCWM_MASK_TEMP_WR;
      end
      // go bits stay set until the measurement reports done; done wins only without a new go
      if (ilim_done && !s_next.ilim_start) begin
         s_next.bank.ilim[`CCWM_B_GO] = 1'b0;
      end
      if (programmed_charge_current_done) begin
         s_next.bank.programmed_charge_current[`CCWM_F_RESULT] = programmed_charge_current_result;
         if (!s_next.programmed_charge_current_start) begin
            s_next.bank.programmed_charge_current[`CCWM_B_GO] = 1'b0;
         end
      end
      // watchdog
      unique case (s_reg.wd_state)
         WD_IDLE: begin
            s_next.wd_cnt = '0;
            if (s_reg.bank.wdog[`CCWM_B_WDOG_EN]) begin
               s_next.wd_state = WD_RUN;
            end
         end
         WD_RUN: begin
            if (!s_reg.bank.wdog[`CCWM_B_WDOG_EN]) begin
               s_next.wd_state = WD_IDLE;
            end else if (reg_wr || reg_rd) begin
               s_next.wd_cnt = '0;
            end else if (s_reg.wd_cnt >= wd_limit(s_reg.bank.wdog[`CCWM_F_WDOG_TO]) - 36'h1) begin
               s_next.wd_cnt     = '0;
               s_next.wd_pending = 1'b1;
               s_next.wd_state   = WD_RESTORE;
            end else begin
               s_next.wd_cnt = s_reg.wd_cnt + 36'h1;
            end
         end
         WD_RESTORE: begin
            if ((s_reg.bank.wdog[`CCWM_B_WDOG_RST] ? RS_CYC1 : RS_CYC0) - 36'h1
                  <= s_reg.wd_cnt) begin
               s_next.restore  = 1'b1;
               s_next.wd_cnt   = '0;
               s_next.bank     = '{`CCWM_RST_WDOG, `CCWM_RST_ILIM,
                                   `CCWM_RST_PROGRAMMED_CHARGE_CURRENT, `CCWM_RST_TEMP};
               s_next.wd_state = WD_IDLE;
            end else begin
               s_next.wd_cnt = s_reg.wd_cnt + 36'h1;
            end
         end
         // code 3 is unused; fall back to idle rather than lock up
         default: begin
            s_next.wd_cnt   = '0;
            s_next.wd_state = WD_IDLE;
         end
      endcase
      // pending expiry event is cleared by a read of the watchdog register
      if (reg_rd && reg_addr == `CCWM_OFF_WDOG && !(s_next.wd_pending && !s_reg.wd_pending)) begin
         s_next.wd_pending = 1'b0;
      end
      // retrigger: release pin for 2 ms, then self-clear the request bit
      if (s_reg.irq_released) begin
         if (s_reg.rt_cnt >= RT_CYC - 36'h1) begin
            s_next.irq_released                = 1'b0;
            s_next.rt_cnt                      = '0;
            // a fresh host request in the same cycle wins over the self-clear
            if (!(wr_hit_wdog && reg_wdata[`CCWM_B_RETRIG])) begin
               s_next.bank.wdog[`CCWM_B_RETRIG] = 1'b0;
            end
         end else begin
            s_next.rt_cnt = s_reg.rt_cnt + 36'h1;
         end
      end else if (s_reg.bank.wdog[`CCWM_B_RETRIG]) begin
         s_next.irq_released = 1'b1;
         s_next.rt_cnt       = '0;
      end
      // read data captured into a flop
      unique case (reg_addr)
         `CCWM_OFF_WDOG: s_next.rdata = s_reg.bank.wdog;
         `CCWM_OFF_ILIM: s_next.rdata = s_reg.bank.ilim;
         `CCWM_OFF_PROGRAMMED_CHARGE_CURRENT: s_next.rdata = s_reg.bank.programmed_charge_current;
         `CCWM_OFF_TEMP: s_next.rdata = s_reg.bank.temp;
         default:        s_next.rdata = 8'h00;
      endcase
      if (!reg_rd) begin
         s_next.rdata = s_reg.rdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_reg            <= '0;
         s_reg.bank       <= '{`CCWM_RST_WDOG, `CCWM_RST_ILIM, `CCWM_RST_PROGRAMMED_CHARGE_CURRENT, `CCWM_RST_TEMP};
         s_reg.wd_state   <= WD_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata          = s_reg.rdata;
   assign ilim_measure_start = s_reg.ilim_start;
   assign programmed_charge_current_measure_start = s_reg.programmed_charge_current_start;
   assign config_restore     = s_reg.restore;
   // pin held released during retrigger window even with events pending
   assign irq_active = !s_reg.irq_released && (s_reg.wd_pending || other_event);

   always_comb begin
      ctrl.halve_current     = s_reg.bank.wdog[`CCWM_B_HALVE];
      ctrl.ocp_high          = s_reg.bank.wdog[`CCWM_B_OCP];
      ctrl.gate_uv_allow     = s_reg.bank.wdog[`CCWM_B_GUV];
      ctrl.ilim_threshold    = s_reg.bank.ilim[`CCWM_F_VTH];
      ctrl.ilim_deglitch     = s_reg.bank.ilim[`CCWM_F_DEG];
      ctrl.ilim_interval     = s_reg.bank.ilim[`CCWM_F_INTVL];
      ctrl.temp_enable       = s_reg.bank.temp[`CCWM_B_TEMP_EN];
      // with regions disabled the full values are forced so no reduction applies
      ctrl.cool_current_full = s_reg.bank.temp[`CCWM_B_COOL_I] | !ctrl.temp_enable;
      ctrl.warm_current_full = s_reg.bank.temp[`CCWM_B_WARM_I] | !ctrl.temp_enable;
      ctrl.cool_voltage_full = s_reg.bank.temp[`CCWM_B_COOL_V] | !ctrl.temp_enable;
      ctrl.warm_voltage_full = s_reg.bank.temp[`CCWM_B_WARM_V] | !ctrl.temp_enable;
   end
endmodule

//--- verification/ccwm_bank_chk.sv
// Purpose: port-level assertions on the control bank
// Assumes: one clock domain, sync reset
// Notes:   long watchdog counts are not watched here
`timescale 1ns/10ps
`include "ccwm_regs.svh"
module ccwm_bank_chk
   import ccwm_pkg::*;
(
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       ilim_measure_start,
   input wire logic       programmed_charge_current_measure_start,
   input wire logic       irq_active,
   input wire ccwm_ctrl_t ctrl
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_ilim_wr;
      reg_wr && reg_addr == `CCWM_OFF_ILIM && reg_wdata[7];
   endsequence
   sequence s_retrig;
      reg_wr && reg_addr == `CCWM_OFF_WDOG && reg_wdata[0];
   endsequence
   a_ilim_go_pulse: assert property (s_ilim_wr |=> ilim_measure_start ##1 !ilim_measure_start)
      else $error("input-limit start missing after go write");
   a_ilim_start_cause: assert property (ilim_measure_start |-> $past(reg_wr && reg_wdata[7]))
      else $error("input-limit start without go write");
   a_programmed_charge_current_go_bit: assert property (reg_wr && reg_addr == `CCWM_OFF_PROGRAMMED_CHARGE_CURRENT
      |=> programmed_charge_current_measure_start == $past(reg_wdata[7])) else $error("charge start wrong");
   a_retrig_release: assert property (s_retrig |-> ##3 (!irq_active [*8]))
      else $error("interrupt not released after retrigger");
   a_wdog_ctrl: assert property (reg_wr && reg_addr == `CCWM_OFF_WDOG
      |=> {ctrl.halve_current, ctrl.ocp_high, ctrl.gate_uv_allow} == $past(reg_wdata[3:1]))
      else $error("misc control levels wrong");
   a_temp_ctrl: assert property (reg_wr && reg_addr == `CCWM_OFF_TEMP
      |=> ctrl.cool_current_full == ($past(reg_wdata[3]) | !$past(reg_wdata[4])))
      else $error("cool current level wrong");
   a_rd_unmapped: assert property (reg_rd && (reg_addr < 8'h0D || reg_addr > 8'h10)
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
endmodule
bind ccwm_bank ccwm_bank_chk u_chk (.mclk(mclk), .reset(reset), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .ilim_measure_start(ilim_measure_start), .programmed_charge_current_measure_start(programmed_charge_current_measure_start),
   .irq_active(irq_active), .ctrl(ctrl));

//--- verification/ccwm_meas_model.sv
// Purpose: measurement units answering the start pulses
// Assumes: starts are one-cycle pulses
// Notes:   result lines show the inverse once the answer is gone
`timescale 1ns/10ps
module ccwm_meas_model (
   input  wire logic       mclk,
   input  wire logic       slow,
   input  wire logic       ilim_go,
   input  wire logic       programmed_charge_current_go,
   input  wire logic [3:0] value,
   output logic            ilim_done,
   output logic            programmed_charge_current_done,
   output logic      [3:0] programmed_charge_current_result
);
   initial begin
      ilim_done = 1'b0;
      programmed_charge_current_done = 1'b0;
      programmed_charge_current_result = 4'hF;
   end
   always @(posedge mclk) begin
      if (ilim_go) begin
         repeat (slow ? 40 : 4) @(posedge mclk);
         ilim_done <= 1'b1;
         @(posedge mclk);
         ilim_done <= 1'b0;
      end
   end
   always @(posedge mclk) begin
      if (programmed_charge_current_go) begin
         repeat (slow ? 40 : 4) @(posedge mclk);
         programmed_charge_current_done <= 1'b1;
         programmed_charge_current_result <= value;
         @(posedge mclk);
         programmed_charge_current_done <= 1'b0;
         programmed_charge_current_result <= ~value;
      end
   end
endmodule

//--- verification/ccwm_bank_bench.sv
// Purpose: self-checking bench of the control bank
// Assumes: reads answered one cycle later
// Notes:   watchdog and retrigger counts too long to run out here
`timescale 1ns/10ps
`include "ccwm_regs.svh"
module ccwm_bank_bench
   import ccwm_pkg::*;
;
   logic       mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, other_event = 0, slow = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, exp_q[$];
   logic       ilim_done, programmed_charge_current_done, ilim_measure_start, programmed_charge_current_measure_start;
   logic       config_restore, irq_active, rd_pend = 0;
   logic [3:0] programmed_charge_current_result, val = 4'h0, r = 4'h0;
   ccwm_ctrl_t ctrl;
   int         n_errors = 0, check_count = 0;
   always #2.5 mclk = ~mclk;
   ccwm_bank uut (.mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .ilim_done(ilim_done), .programmed_charge_current_done(programmed_charge_current_done), .programmed_charge_current_result(programmed_charge_current_result),
      .other_event(other_event), .ilim_measure_start(ilim_measure_start),
      .programmed_charge_current_measure_start(programmed_charge_current_measure_start), .config_restore(config_restore),
      .irq_active(irq_active), .ctrl(ctrl));
   ccwm_meas_model u_meas (.mclk(mclk), .slow(slow), .ilim_go(ilim_measure_start),
      .programmed_charge_current_go(programmed_charge_current_measure_start), .value(val), .ilim_done(ilim_done),
      .programmed_charge_current_done(programmed_charge_current_done), .programmed_charge_current_result(programmed_charge_current_result));
   task print_verdict;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge mclk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, w};
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
      @(negedge mclk);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge mclk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
   endtask
   task wait_done(input logic on_programmed_charge_current);
      int i;
      for (i = 0; i < 100; i++) begin
         @(negedge mclk);
         if ((on_programmed_charge_current ? programmed_charge_current_done : ilim_done) === 1'b1) break;
      end
      if (i == 100) begin
         n_errors++;
         print_verdict();
      end
   endtask
   // read data checked one cycle after each read strobe, oldest note first
   always @(negedge mclk) begin
      if (rd_pend) begin
         if (exp_q.size() == 0) check(reg_rdata, ~reg_rdata);
         else check(reg_rdata, exp_q.pop_front());
      end
      rd_pend = reg_rd;
   end
   initial begin
      void'($urandom(32'h0ACD6386));
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      rd(`CCWM_OFF_WDOG, `CCWM_RST_WDOG);
      rd(`CCWM_OFF_ILIM, `CCWM_RST_ILIM);
      rd(`CCWM_OFF_PROGRAMMED_CHARGE_CURRENT, `CCWM_RST_PROGRAMMED_CHARGE_CURRENT);
      rd(`CCWM_OFF_TEMP, `CCWM_RST_TEMP);
      wr(8'h11, 8'hFF);
      rd(8'h11, 8'h00);
      for (int i = 0; i < 2; i++) begin
         slow <= i[0];
         d = 8'($urandom);
         d[7] = i[0];
         d[0] = 1'b0;
         wr(`CCWM_OFF_WDOG, d);
         rd(`CCWM_OFF_WDOG, d);
         check({5'h00, ctrl.halve_current, ctrl.ocp_high, ctrl.gate_uv_allow}, {5'h00, d[3:1]});
         d = 8'($urandom) | 8'h80;
         wr(`CCWM_OFF_ILIM, d);
         check({1'b0, ctrl.ilim_deglitch, ctrl.ilim_interval, ctrl.ilim_threshold}, {1'b0, d[6:0]});
         wait_done(1'b0);
         rd(`CCWM_OFF_ILIM, {1'b0, d[6:0]});
         wr(`CCWM_OFF_PROGRAMMED_CHARGE_CURRENT, 8'h7F);
         rd(`CCWM_OFF_PROGRAMMED_CHARGE_CURRENT, {1'b0, r, 3'h0});
         r = 4'($urandom);
         val <= r;
         wr(`CCWM_OFF_PROGRAMMED_CHARGE_CURRENT, 8'hFF);
         wait_done(1'b1);
         rd(`CCWM_OFF_PROGRAMMED_CHARGE_CURRENT, {1'b0, r, 3'h0});
         d = 8'($urandom);
         d[4] = i[0];
         wr(`CCWM_OFF_TEMP, d);
         rd(`CCWM_OFF_TEMP, d & `CCWM_MASK_TEMP_WR);
         check({3'h0, ctrl.temp_enable, ctrl.cool_current_full, ctrl.warm_current_full, ctrl.cool_voltage_full, ctrl.warm_voltage_full}, {3'h0, d[4], d[3:0] | {4{~d[4]}}});
      end
      @(posedge mclk);
      other_event <= 1'b1;
      repeat (2) @(negedge mclk);
      check({7'h00, irq_active}, 8'h01);
      wr(`CCWM_OFF_WDOG, 8'h53);
      repeat (2) @(negedge mclk);
      check({7'h00, irq_active}, 8'h00);
      rd(`CCWM_OFF_WDOG, 8'h53);
      check({7'h00, config_restore}, 8'h00);
      print_verdict();
   end
endmodule
